// [rtl/sensor_irq_pkg.sv]
/*
 * Shared constants and carrier types for the sensor event flag,
 * interrupt mask and FIFO byte count block.
 * Assumes a register port already decoded from the serial bus,
 * one request per clk cycle, all on the same clock.
 */
`default_nettype none

package sensor_irq_pkg;

	// Register addresses on the serial register port
	localparam logic [6:0] ADDR_INT_MASK     = 7'h48;
	localparam logic [6:0] ADDR_EVENT_STATUS = 7'h49;
	localparam logic [6:0] ADDR_SLAVE_STATE  = 7'h4a;

	// Values after reset
	localparam logic [7:0] MASK_RESET  = 8'hff;
	localparam logic [7:0] FLAGS_RESET = 8'h00;
	localparam logic [7:0] COUNT_RESET = 8'h00;
	localparam logic       SLAVE_RESET = 1'b0;

	// Field positions inside the status and slave state words, and the source flag count
	localparam int FLAG_LSB      = 0;
	localparam int FLAG_FIFO_LVL = 7;
	localparam int COUNT_LSB     = 8;
	localparam int FLUSH_BIT     = 15;
	localparam int SLAVE_MATCH   = 0;
	localparam int NUM_SRC_FLAGS = 7;

	// Flag bit order: prox_on_level1 .. watchdog, then FIFO level
	typedef enum {
		EV_PROX_ON_LEVEL1,
		EV_PROX_OFF_LEVEL1,
		EV_PROX_ON_LEVEL2,
		EV_PROX_OFF_LEVEL2,
		EV_GESTURE,
		EV_SAMPLE,
		EV_WATCHDOG
	} event_src_t;

	// One register access from the serial slave
	typedef struct packed {
		logic [6:0]  addr;
		logic        wr;
		logic        rd;
		logic [15:0] wdata;
	} reg_req_t;

	// Event pulses from the sensing core and the serial slave
	typedef struct packed {
		logic [NUM_SRC_FLAGS-1:0] src;
		logic                     slave_match;
		logic                     byte_in;
		logic                     byte_out;
	} event_in_t;

endpackage

`default_nettype wire

// [rtl/sensor_irq_status.sv]
/*
 * Event flags, interrupt mask, FIFO byte count and serial slave
 * status for the proximity and gesture sensor.
 * Assumes every input is driven by logic on clk (no synchronisers);
 * event inputs are one-cycle pulses, the FIFO threshold comes from
 * the configuration register held elsewhere.
 */
`timescale 1ns/1ps
`default_nettype none

module sensor_irq_status (
	input  wire logic                      clk,
	input  wire logic                      sys_rst,
	input  wire sensor_irq_pkg::reg_req_t  req,
	input  wire sensor_irq_pkg::event_in_t ev,
	input  wire logic [3:0]                queue_level_threshold,
	output logic [15:0]                    reg_rdata,
	output logic                           irq
);

	logic [7:0]  flags_ff;
	logic [7:0]  nxt_flags;
	logic [7:0]  mask_ff;
	logic [7:0]  count_ff;
	logic [7:0]  nxt_count;
	logic        slave_ff;
	logic        nxt_slave;
	logic [15:0] rdata_ff;
	logic [15:0] nxt_rdata;
	logic [7:0]  set_vec;
	logic        fifo_above;
	logic        wr_status;
	logic        rd_status;
	logic        wr_mask;
	logic        rd_slave;

	// Address decode of the register port
	assign wr_status = req.wr && (req.addr == sensor_irq_pkg::ADDR_EVENT_STATUS);
	assign rd_status = req.rd && (req.addr == sensor_irq_pkg::ADDR_EVENT_STATUS);
	assign wr_mask   = req.wr && (req.addr == sensor_irq_pkg::ADDR_INT_MASK);
	assign rd_slave  = req.rd && (req.addr == sensor_irq_pkg::ADDR_SLAVE_STATE);

	// Level compare, so the flag re-arms right after a clear while still above
	assign fifo_above = count_ff > {4'h0, queue_level_threshold};
	assign set_vec    = {fifo_above, ev.src};

	// Flag update: read and W1C clear first, new events win over both
	always_comb begin
		nxt_flags = flags_ff;
		if (rd_status) begin
			nxt_flags = sensor_irq_pkg::FLAGS_RESET;
		end
		if (wr_status) begin
			nxt_flags = nxt_flags & ~req.wdata[7:0];
		end
		nxt_flags = nxt_flags | set_vec;
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			flags_ff <= sensor_irq_pkg::FLAGS_RESET;
		end else begin
			flags_ff <= nxt_flags;
		end
	end

	// Mask, active high, same bit order as the flags
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			mask_ff <= sensor_irq_pkg::MASK_RESET;
		end else if (wr_mask) begin
			mask_ff <= req.wdata[7:0];
		end
	end

	// Byte count: clears first, then this cycle's push and pop
	always_comb begin
		nxt_count = count_ff;
		if (rd_status) begin
			nxt_count = sensor_irq_pkg::COUNT_RESET;
		end else if (wr_status && req.wdata[sensor_irq_pkg::FLUSH_BIT]) begin
			nxt_count[6:0] = 7'h00;
		end
		nxt_count = nxt_count + {7'h00, ev.byte_in} - {7'h00, ev.byte_out};
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			count_ff <= sensor_irq_pkg::COUNT_RESET;
		end else begin
			count_ff <= nxt_count;
		end
	end

	// Slave match is sticky until its status register is read
	assign nxt_slave = (rd_slave ? sensor_irq_pkg::SLAVE_RESET : slave_ff) | ev.slave_match;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			slave_ff <= sensor_irq_pkg::SLAVE_RESET;
		end else begin
			slave_ff <= nxt_slave;
		end
	end

	// Read data captures the value before the self-clear takes effect
	always_comb begin
		case (req.addr)
			sensor_irq_pkg::ADDR_INT_MASK: begin
				nxt_rdata = {8'h00, mask_ff};
			end
			sensor_irq_pkg::ADDR_EVENT_STATUS: begin
				nxt_rdata = {count_ff, flags_ff};
			end
			sensor_irq_pkg::ADDR_SLAVE_STATE: begin
				nxt_rdata = {15'h0000, slave_ff};
			end
			default: begin
				nxt_rdata = 16'h0000;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rdata_ff <= 16'h0000;
		end else if (req.rd) begin
			rdata_ff <= nxt_rdata;
		end
	end

	assign reg_rdata = rdata_ff;
	// Gated from the flag, mask and slave flops, not registered itself, so it can glitch
	assign irq = (|(flags_ff & ~mask_ff)) | slave_ff;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	sequence s_status_read;
		rd_status && (set_vec == 8'h00) && !wr_status;
	endsequence

	sequence s_flags_gone;
		flags_ff == 8'h00;
	endsequence

	property p_w1c_clears;
		wr_status && req.wdata[0] && !ev.src[0] |=> !flags_ff[0];
	endproperty
	a_w1c_clears: assert property (p_w1c_clears) else $error("flag 0 not cleared by write of one");

	property p_w0_keeps;
		wr_status && !rd_status && flags_ff[1] && !req.wdata[1] |=> flags_ff[1];
	endproperty
	a_w0_keeps: assert property (p_w0_keeps) else $error("flag 1 lost on write of zero");

	property p_read_clears;
		s_status_read |=> s_flags_gone;
	endproperty
	a_read_clears: assert property (p_read_clears) else $error("flags survive a status read");

	property p_read_returns;
		rd_status |=> reg_rdata == {$past(count_ff), $past(flags_ff)};
	endproperty
	a_read_returns: assert property (p_read_returns) else $error("status read data wrong");

	property p_fifo_flag;
		count_ff > {4'h0, queue_level_threshold} |=> flags_ff[sensor_irq_pkg::FLAG_FIFO_LVL];
	endproperty
	a_fifo_flag: assert property (p_fifo_flag) else $error("FIFO level flag not set");

	property p_flush;
		wr_status && req.wdata[15] && !rd_status && !ev.byte_in && !ev.byte_out |=> count_ff[6:0] == 7'h00;
	endproperty
	a_flush: assert property (p_flush) else $error("count not flushed");

	property p_slave_irq;
		ev.slave_match |=> slave_ff && irq;
	endproperty
	a_slave_irq: assert property (p_slave_irq) else $error("slave match lost");

	property p_mask_blocks;
		(flags_ff & ~mask_ff) == 8'h00 && !slave_ff |-> !irq;
	endproperty
	a_mask_blocks: assert property (p_mask_blocks) else $error("masked event drives irq");

	property p_irq_on;
		(flags_ff & ~mask_ff) != 8'h00 |-> irq;
	endproperty
	a_irq_on: assert property (p_irq_on) else $error("unmasked flag without irq");

	property p_mask_write;
		wr_mask ##1 !wr_mask |-> (flags_ff & ~mask_ff) == (flags_ff & ~$past(req.wdata[7:0], 1));
	endproperty
	a_mask_write: assert property (p_mask_write) else $error("mask write not applied");

	// Set beats any clear in the same cycle, so no event is lost
	property p_event_sets;
		ev.src != 7'h00 |=> (flags_ff[6:0] & $past(ev.src)) == $past(ev.src);
	endproperty
	a_event_sets: assert property (p_event_sets) else $error("event pulse did not set its flag");

	// Flush leaves the top count bit alone
	property p_flush_keeps_top;
		wr_status && req.wdata[15] && !rd_status && !ev.byte_in && !ev.byte_out |=> count_ff[7] == $past(count_ff[7]);
	endproperty
	a_flush_keeps_top: assert property (p_flush_keeps_top) else $error("flush touched count bit 7");

	property p_slave_read_clears;
		rd_slave && !ev.slave_match |=> !slave_ff;
	endproperty
	a_slave_read_clears: assert property (p_slave_read_clears) else $error("slave match survives read");

endmodule

`default_nettype wire

// [test/host_model.sv]
/* Host side of the register port: one access per call.
   Assumes the caller waits for each call to return. */
`timescale 1ns/1ps
`default_nettype none
module host_model (
	input  wire logic                   clk,
	output var sensor_irq_pkg::reg_req_t req
);
	initial req = '0;
	// Strobe stands one edge, then drops so no access is taken twice
	task automatic access(input logic [6:0] a, input logic w, input logic [15:0] d);
		@(negedge clk);
		req <= '{addr: a, wr: w, rd: !w, wdata: d};
		@(negedge clk);
		req <= '0;
	endtask
endmodule
`default_nettype wire

// [test/tb_sensor_irq_status.sv]
/* Scenario bench for the event flag and interrupt block.
   Assumes host_model as register master; inputs move on falling edges. */
`timescale 1ns/1ps
`default_nettype none
module tb_sensor_irq_status;
	logic                      clk = 1'b0;
	logic                      sys_rst = 1'b1;
	sensor_irq_pkg::reg_req_t  req;
	sensor_irq_pkg::event_in_t ev = '0;
	logic [3:0]                thr = 4'h2;
	logic [15:0]               rdata;
	logic                      irq;
	int                        n_errors = 0;
	int                        n_tests = 0;
	always #2 clk = ~clk;
	host_model i_host_model (.clk(clk), .req(req));
	sensor_irq_status i_sensor_irq_status (.clk(clk), .sys_rst(sys_rst), .req(req), .ev(ev),
		.queue_level_threshold(thr), .reg_rdata(rdata), .irq(irq));
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Read data is settled at the falling edge after the taking edge
	task automatic rd(input logic [6:0] a, input logic [15:0] exp);
		i_host_model.access(a, 1'b0, 16'h0000);
		chk("rdata", exp, rdata);
	endtask
	task automatic wr(input logic [6:0] a, input logic [15:0] d);
		i_host_model.access(a, 1'b1, d);
	endtask
	// Packed order: src[9:3], slave_match, byte_in, byte_out
	task automatic pulse(input logic [9:0] e, input int n);
		repeat (n) begin
			@(negedge clk);
			ev <= sensor_irq_pkg::event_in_t'(e);
			@(negedge clk);
			ev <= '0;
		end
	endtask
	task automatic t_reset();
		rd(7'h48, 16'h00ff);
		rd(7'h4a, 16'h0000);
		rd(7'h10, 16'h0000);
		chk("irq", 16'h0000, irq);
	endtask
	task automatic t_masked();
		pulse(10'h3f8, 1);
		chk("irq", 16'h0000, irq);
		rd(7'h49, 16'h007f);
		rd(7'h49, 16'h0000);
	endtask
	task automatic t_w1c();
		wr(7'h48, 16'hff00);
		rd(7'h48, 16'h0000);
		pulse(10'h090, 1);
		chk("irq", 16'h0001, irq);
		wr(7'h49, 16'h0001);
		wr(7'h49, 16'h0002);
		chk("irq", 16'h0001, irq);
		wr(7'h49, 16'h0010);
		chk("irq", 16'h0000, irq);
		wr(7'h48, 16'h00fe);
		pulse(10'h010, 1);
		chk("irq", 16'h0000, irq);
		rd(7'h49, 16'h0002);
	endtask
	task automatic t_fifo();
		wr(7'h48, 16'h007f);
		pulse(10'h002, 2);
		chk("irq", 16'h0000, irq);
		pulse(10'h002, 2);
		pulse(10'h001, 1);
		chk("irq", 16'h0001, irq);
		rd(7'h49, 16'h0380);
		rd(7'h49, 16'h0080);
		rd(7'h49, 16'h0000);
		thr <= 4'h3; // Equal to the threshold must not flag
		pulse(10'h002, 3);
		wr(7'h49, 16'h8000);
		rd(7'h49, 16'h0000);
		pulse(10'h002, 129);
		wr(7'h49, 16'h8000);
		rd(7'h49, 16'h8080);
		rd(7'h49, 16'h0080);
	endtask
	task automatic t_slave();
		wr(7'h48, 16'h00ff);
		wr(7'h4a, 16'h0001);
		rd(7'h4a, 16'h0000);
		pulse(10'h004, 1);
		chk("irq", 16'h0001, irq);
		rd(7'h4a, 16'h0001);
		chk("irq", 16'h0000, irq);
	endtask
	task automatic stop_test();
		$display("tests %0d errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// Main sequence after a ten cycle reset
	initial begin
		repeat (10) @(posedge clk);
		@(negedge clk);
		sys_rst <= 1'b0;
		t_reset();
		t_masked();
		t_w1c();
		t_fifo();
		t_slave();
		stop_test();
	end
	// Guard against a hang; expiry counts as a mismatch
	initial begin
		#100000;
		n_errors++;
		stop_test();
	end
endmodule
`default_nettype wire
